// >>> irfc_frame_capture.sv
// Frame capture, interval counting and repeat detection for the IR decoder
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module irfc_frame_capture #(
  parameter int FRAME_MAX = 64
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        sym_valid,
  input  wire logic        sym_bit,
  input  wire logic        frame_done,
  input  wire logic        hold_first,
  input  wire logic [9:0]  pulse_width,
  input  wire logic        pulse_valid,
  output logic      [3:0]  decode_mode,
  output logic             half_bit_match,
  output logic             whole_bit_match,
  output logic             frame_valid,
  output logic             repeat_indicator
);
  localparam int IW = irfc_pkg::IVL_W;
  localparam int TW = irfc_pkg::TICK_DIV_W;
  localparam logic [IW-1:0] IVL_MAX = {IW{1'b1}};

  // Frame storage is exactly two words; the divider must reach the slow tick count
  if (FRAME_MAX != 64) begin : g_chk_frame
    $error("irfc_frame_capture: FRAME_MAX must be 64");
  end
  if (irfc_pkg::TICK_SLOW_CYC > (1 << TW)) begin : g_chk_tick
    $error("irfc_frame_capture: tick divider too narrow");
  end

  logic [31:0]         ctrl_r;
  logic [31:0]         dur2_r;
  logic [31:0]         dur3_r;
  logic [IW-1:0]       rpt_limit_r;
  logic [IW-1:0]       ivl_cnt_r;
  logic [IW-1:0]       ivl_last_r;
  logic [irfc_pkg::TICK_DIV_W-1:0] tick_div_r;
  logic [63:0]         acc_r;
  logic [6:0]          bit_cnt_r;
  logic [63:0]         prev_frame_r;
  logic [31:0]         captured_word_low;
  logic [31:0]         captured_word_high;
  logic                low_valid_r;
  logic                high_valid_r;
  logic                repeat_r;
  logic [31:0]         rdata_nxt;
  logic                tick_now;
  logic                ivl_step;
  logic                capture;
  logic                rd_low;
  logic                rd_high;
  logic                rd_clr_en;
  logic                time_ok;
  logic                rpt_nxt;
  logic [5:0]          rpt_idx;
  logic [irfc_pkg::TICK_DIV_W-1:0] tick_last;

  assign rpt_idx   = ctrl_r[irfc_pkg::F_RPT_IDX_LO +: 6];
  assign rd_low    = reg_rd && reg_addr == irfc_pkg::IDX_CAP_LOW;
  assign rd_high   = reg_rd && reg_addr == irfc_pkg::IDX_CAP_HIGH;
  assign rd_clr_en = !ctrl_r[irfc_pkg::F_NO_RDCLR];
  // Keep-first: a held frame blocks new captures until the low word is read
  assign capture   = frame_done && !(hold_first && low_valid_r);

  // Control and window registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r      <= irfc_pkg::CTRL_RESET;
      dur2_r      <= '0;
      dur3_r      <= '0;
      rpt_limit_r <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        irfc_pkg::IDX_CTRL:      ctrl_r <= reg_wdata & irfc_pkg::CTRL_WMASK;
        irfc_pkg::IDX_DUR2:      dur2_r <= reg_wdata & irfc_pkg::DUR_WMASK;
        irfc_pkg::IDX_DUR3:      dur3_r <= reg_wdata & irfc_pkg::DUR_WMASK;
        irfc_pkg::IDX_RPT_LIMIT: rpt_limit_r <= reg_wdata[IW-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      decode_mode <= '0;
    end else begin
      decode_mode <= ctrl_r[3:0];
    end
  end

  // Duration window comparisons on each measured pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      half_bit_match  <= 1'b0;
      whole_bit_match <= 1'b0;
    end else begin
      half_bit_match  <= pulse_valid && pulse_width >= dur2_r[irfc_pkg::DUR_W-1:0]
                         && pulse_width <= dur2_r[irfc_pkg::F_DUR_MAX_LO +: 10];
      whole_bit_match <= pulse_valid && pulse_width >= dur3_r[irfc_pkg::DUR_W-1:0]
                         && pulse_width <= dur3_r[irfc_pkg::F_DUR_MAX_LO +: 10];
    end
  end

  // Timebase tick for the interval counter
  assign tick_last = ctrl_r[irfc_pkg::F_TICK_FAST]
                   ? TW'(irfc_pkg::TICK_FAST_CYC - 1)
                   : TW'(irfc_pkg::TICK_SLOW_CYC - 1);
  assign tick_now  = tick_div_r >= tick_last;

  always_ff @(posedge clk) begin
    if (rst || tick_now) begin
      tick_div_r <= '0;
    end else begin
      tick_div_r <= tick_div_r + 1'b1;
    end
  end

  assign ivl_step = ctrl_r[irfc_pkg::F_SYSCLK_SEL] ? 1'b1 : tick_now;

  // Frame-to-frame interval counter
  always_ff @(posedge clk) begin
    if (rst) begin
      ivl_cnt_r  <= '0;
      ivl_last_r <= '0;
    end else if (capture) begin
      ivl_cnt_r  <= '0;
      ivl_last_r <= ivl_cnt_r;
    end else if (ctrl_r[irfc_pkg::F_IVL_EN] && ivl_step && ivl_cnt_r != IVL_MAX) begin
      ivl_cnt_r  <= ivl_cnt_r + 1'b1;
    end
  end

  // Bit assembly
  always_ff @(posedge clk) begin
    if (rst || frame_done) begin
      acc_r     <= '0;
      bit_cnt_r <= '0;
    end else if (sym_valid && bit_cnt_r < 7'd64) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
      if (ctrl_r[irfc_pkg::F_MSB_FIRST]) begin
        acc_r <= {acc_r[62:0], sym_bit};
      end else begin
        acc_r[bit_cnt_r[5:0]] <= sym_bit;
      end
    end
  end

  // Repeat decision for the frame now being captured
  assign time_ok = !ctrl_r[irfc_pkg::F_TIME_CHK] || ivl_cnt_r < rpt_limit_r;
  always_comb begin
    rpt_nxt = 1'b0;
    if (ctrl_r[irfc_pkg::F_CMP_FRAME]) begin
      rpt_nxt = (acc_r == prev_frame_r) && time_ok;
    end else if (ctrl_r[irfc_pkg::F_CMP_BIT]) begin
      rpt_nxt = acc_r[rpt_idx] && time_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_frame_r <= '0;
      repeat_r     <= 1'b0;
    end else if (capture) begin
      prev_frame_r <= acc_r;
      repeat_r     <= rpt_nxt;
    end
  end

  // Captured words; a capture in the read cycle wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      captured_word_low <= '0;
      low_valid_r       <= 1'b0;
    end else if (capture) begin
      captured_word_low <= acc_r[31:0];
      low_valid_r       <= 1'b1;
    end else if (rd_low) begin
      low_valid_r       <= 1'b0;
      if (rd_clr_en) begin
        captured_word_low <= '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      captured_word_high <= '0;
      high_valid_r       <= 1'b0;
    end else if (capture && bit_cnt_r > 7'd32) begin
      captured_word_high <= acc_r[63:32];
      high_valid_r       <= 1'b1;
    end else if (rd_high) begin
      high_valid_r       <= 1'b0;
      if (rd_clr_en) begin
        captured_word_high <= '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_valid      <= 1'b0;
      repeat_indicator <= 1'b0;
    end else begin
      frame_valid      <= capture || (low_valid_r && !rd_low);
      repeat_indicator <= capture ? rpt_nxt : repeat_r;
    end
  end

  // Read path
  always_comb begin
    rdata_nxt = '0;
    case (reg_addr)
      irfc_pkg::IDX_STATUS: begin
        rdata_nxt[irfc_pkg::F_ST_HIGH_VAL] = high_valid_r;
        rdata_nxt[irfc_pkg::F_ST_LOW_VAL]  = low_valid_r;
        rdata_nxt[irfc_pkg::F_ST_REPEAT]   = repeat_r;
      end
      irfc_pkg::IDX_CTRL:      rdata_nxt = ctrl_r;
      irfc_pkg::IDX_DUR2:      rdata_nxt = dur2_r;
      irfc_pkg::IDX_DUR3:      rdata_nxt = dur3_r;
      irfc_pkg::IDX_CAP_LOW:   rdata_nxt = captured_word_low;
      irfc_pkg::IDX_CAP_HIGH:  rdata_nxt = captured_word_high;
      irfc_pkg::IDX_LAST_IVL:  rdata_nxt[IW-1:0] = ivl_last_r;
      irfc_pkg::IDX_LIVE_IVL:  rdata_nxt[IW-1:0] = ivl_cnt_r;
      irfc_pkg::IDX_RPT_LIMIT: rdata_nxt[IW-1:0] = rpt_limit_r;
      default:                 rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : '0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ivl_saturate;
    ivl_cnt_r == IVL_MAX && !capture |=> ivl_cnt_r == IVL_MAX;
  endproperty
  a_ivl_saturate: assert property (p_ivl_saturate) else $error("interval left saturation");

  property p_ivl_clear;
    capture |=> ivl_cnt_r == '0;
  endproperty
  a_ivl_clear: assert property (p_ivl_clear) else $error("interval not cleared");

  property p_sysclk_step;
    ctrl_r[irfc_pkg::F_SYSCLK_SEL] && ctrl_r[irfc_pkg::F_IVL_EN] && !capture
      && ivl_cnt_r != IVL_MAX |=> ivl_cnt_r == $past(ivl_cnt_r) + 1'b1;
  endproperty
  a_sysclk_step: assert property (p_sysclk_step) else $error("sysclk step missing");

  property p_tick_hold;
    !ctrl_r[irfc_pkg::F_SYSCLK_SEL] && !tick_now && !capture |=> $stable(ivl_cnt_r);
  endproperty
  a_tick_hold: assert property (p_tick_hold) else $error("counter moved off tick");

  // Cycles since the last tick, and whether the fast timebase stayed selected since it
  logic [7:0] tick_gap_r;
  logic       fast_held_r;

  always_ff @(posedge clk) begin
    if (rst || tick_now) begin
      tick_gap_r <= '0;
    end else if (tick_gap_r != 8'hFF) begin
      tick_gap_r <= tick_gap_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !ctrl_r[irfc_pkg::F_TICK_FAST]) begin
      fast_held_r <= 1'b0;
    end else if (tick_now) begin
      fast_held_r <= 1'b1;
    end
  end

  property p_fast_tick;
    fast_held_r && ctrl_r[irfc_pkg::F_TICK_FAST]
      |-> tick_now == (tick_gap_r == 8'(irfc_pkg::TICK_FAST_CYC - 1));
  endproperty
  a_fast_tick: assert property (p_fast_tick) else $error("10 us tick period wrong");

  property p_last_ivl;
    capture |=> ivl_last_r == $past(ivl_cnt_r);
  endproperty
  a_last_ivl: assert property (p_last_ivl) else $error("last interval wrong");

  property p_live_read;
    reg_rd && reg_addr == irfc_pkg::IDX_LIVE_IVL |=> reg_rdata[IW-1:0] == $past(ivl_cnt_r);
  endproperty
  a_live_read: assert property (p_live_read) else $error("live interval read wrong");

  property p_rd_clear;
    rd_low && rd_clr_en && !capture |=> captured_word_low == '0 && !low_valid_r;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("low word not cleared");

  property p_hold_first;
    hold_first && low_valid_r && !rd_low |=> $stable(captured_word_low);
  endproperty
  a_hold_first: assert property (p_hold_first) else $error("held frame overwritten");

  property p_time_limit;
    capture && ctrl_r[irfc_pkg::F_TIME_CHK] && ivl_cnt_r >= rpt_limit_r |=> !repeat_r;
  endproperty
  a_time_limit: assert property (p_time_limit) else $error("late frame flagged repeat");

  property p_frame_cmp;
    capture && ctrl_r[irfc_pkg::F_CMP_FRAME] && acc_r == prev_frame_r && time_ok
      |=> repeat_r ##0 repeat_indicator;
  endproperty
  a_frame_cmp: assert property (p_frame_cmp) else $error("frame repeat missed");

  property p_bit_cmp;
    capture && !ctrl_r[irfc_pkg::F_CMP_FRAME] && ctrl_r[irfc_pkg::F_CMP_BIT]
      && !ctrl_r[irfc_pkg::F_TIME_CHK] |=> repeat_r == $past(acc_r[rpt_idx]);
  endproperty
  a_bit_cmp: assert property (p_bit_cmp) else $error("bit repeat wrong");

  property p_high_valid;
    capture && bit_cnt_r > 7'd32 |=> high_valid_r && captured_word_high == $past(acc_r[63:32]);
  endproperty
  a_high_valid: assert property (p_high_valid) else $error("upper word not stored");

  property p_lsb_place;
    sym_valid && !frame_done && !ctrl_r[irfc_pkg::F_MSB_FIRST] && bit_cnt_r < 7'd64
      |=> acc_r[$past(bit_cnt_r[5:0])] == $past(sym_bit);
  endproperty
  a_lsb_place: assert property (p_lsb_place) else $error("bit stored at wrong place");

  property p_low_store;
    capture |=> captured_word_low == $past(acc_r[31:0]) && low_valid_r;
  endproperty
  a_low_store: assert property (p_low_store) else $error("low word not stored");

  property p_low_read;
    rd_low && !capture |=> !low_valid_r && !frame_valid;
  endproperty
  a_low_read: assert property (p_low_read) else $error("valid not cleared by read");

  property p_mode_copy;
    1'b1 |=> decode_mode == $past(ctrl_r[3:0]);
  endproperty
  a_mode_copy: assert property (p_mode_copy) else $error("format select not passed");

  c_repeat_frame: cover property (capture && rpt_nxt && ctrl_r[irfc_pkg::F_CMP_FRAME]);
  c_saturate:     cover property (ivl_cnt_r == IVL_MAX);
  c_long_frame:   cover property (capture && bit_cnt_r > 7'd32);
  c_held_drop:    cover property (frame_done && !capture);
endmodule

// >>> irfc_pkg.sv
// Register map, field positions and timing constants of the IR frame capture block
package irfc_pkg;
  localparam int          ADDR_W        = 8;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_STATUS    = 8'h16;
  localparam logic [7:0]  IDX_CTRL      = 8'h18;
  localparam logic [7:0]  IDX_DUR2      = 8'h19;
  localparam logic [7:0]  IDX_DUR3      = 8'h1A;
  localparam logic [7:0]  IDX_CAP_LOW   = 8'h1B;
  localparam logic [7:0]  IDX_LAST_IVL  = 8'h1C;
  localparam logic [7:0]  IDX_LIVE_IVL  = 8'h1D;
  localparam logic [7:0]  IDX_CAP_HIGH  = 8'h1E;
  localparam logic [7:0]  IDX_RPT_LIMIT = 8'h1F;
  // Control register fields
  localparam int          F_RPT_IDX_LO  = 16;
  localparam int          F_TICK_FAST   = 15;
  localparam int          F_SYSCLK_SEL  = 14;
  localparam int          F_IVL_EN      = 13;
  localparam int          F_TIME_CHK    = 12;
  localparam int          F_CMP_FRAME   = 11;
  localparam int          F_CMP_BIT     = 10;
  localparam int          F_NO_RDCLR    = 9;
  localparam int          F_MSB_FIRST   = 8;
  localparam logic [31:0] CTRL_WMASK    = 32'h003F_FF0F;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  // Duration window fields
  localparam int          F_DUR_MAX_LO  = 16;
  localparam int          DUR_W         = 10;
  localparam logic [31:0] DUR_WMASK     = 32'h03FF_03FF;
  // Status register fields
  localparam int          F_ST_HIGH_VAL = 31;
  localparam int          F_ST_LOW_VAL  = 3;
  localparam int          F_ST_REPEAT   = 0;
  // Decode formats
  localparam logic [3:0]  FMT_NO_LEADER = 4'h1;
  localparam logic [3:0]  FMT_MEASURE   = 4'h2;
  // Interval counter
  localparam int          IVL_W         = 20;
  // Timing
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          TICK_SLOW_US  = 100;
  localparam int          TICK_FAST_US  = 10;
  localparam int          TICK_SLOW_CYC = (TICK_SLOW_US * 1000) / CLK_PERIOD_NS;
  localparam int          TICK_FAST_CYC = (TICK_FAST_US * 1000) / CLK_PERIOD_NS;
  localparam int          TICK_DIV_W    = 10;
endpackage

// >>> irfc_remote_model.sv
// Behavioural IR receiver front end: decoded bits, frame ends, pulse widths
`timescale 1ns/100ps
module irfc_remote_model (
  input  wire logic       clk,
  output logic            sym_valid,
  output logic            sym_bit,
  output logic            frame_done,
  output logic [9:0]      pulse_width,
  output logic            pulse_valid
);
  initial begin
    sym_valid   = 1'b0;
    sym_bit     = 1'b0;
    frame_done  = 1'b0;
    pulse_width = 10'h000;
    pulse_valid = 1'b0;
  end

  // Data lines released at the end of a frame or pulse show the inverse of their last value; sym_bit holds during bit gaps
  task automatic send_frame(input logic [63:0] bits, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) begin
        @(posedge clk);
        sym_valid <= 1'b0;
      end
      @(posedge clk);
      sym_valid <= 1'b1;
      sym_bit   <= bits[i];
    end
    @(posedge clk);
    sym_valid  <= 1'b0;
    sym_bit    <= ~sym_bit;
    frame_done <= 1'b1;
    @(posedge clk);
    frame_done <= 1'b0;
  endtask

  task automatic send_pulse(input logic [9:0] w);
    @(posedge clk);
    pulse_valid <= 1'b1;
    pulse_width <= w;
    @(posedge clk);
    pulse_valid <= 1'b0;
    pulse_width <= ~w;
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the IR frame capture block
`timescale 1ns/100ps
module tb_top;
  logic        clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        sym_valid;
  logic        sym_bit;
  logic        frame_done;
  logic        hold_first;
  logic [9:0]  pulse_width;
  logic        pulse_valid;
  logic [3:0]  decode_mode;
  logic        half_bit_match;
  logic        whole_bit_match;
  logic        frame_valid;
  logic        repeat_indicator;
  int          n_mismatch;
  int          cmp_count;

  irfc_frame_capture dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sym_valid(sym_valid),
    .sym_bit(sym_bit), .frame_done(frame_done), .hold_first(hold_first),
    .pulse_width(pulse_width), .pulse_valid(pulse_valid), .decode_mode(decode_mode),
    .half_bit_match(half_bit_match), .whole_bit_match(whole_bit_match),
    .frame_valid(frame_valid), .repeat_indicator(repeat_indicator));

  irfc_remote_model rm_u (.clk(clk), .sym_valid(sym_valid), .sym_bit(sym_bit),
    .frame_done(frame_done), .pulse_width(pulse_width), .pulse_valid(pulse_valid));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_le(input logic [31:0] got, input logic [31:0] lim);
    cmp_count++;
    if ((got <= lim) !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h max=%h", $time, got, lim);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 8; i++) expect_reg(8'h18 + i[7:0], 32'h0000_0000);
    expect_reg(irfc_pkg::IDX_STATUS, 32'h0000_0000);
    wr(irfc_pkg::IDX_CTRL, 32'hFFFF_FFFF);
    expect_reg(irfc_pkg::IDX_CTRL, 32'h003F_FF0F);
    wr(irfc_pkg::IDX_DUR2, 32'hFFFF_FFFF);
    expect_reg(irfc_pkg::IDX_DUR2, 32'h03FF_03FF);
    wr(irfc_pkg::IDX_DUR3, 32'hFFFF_FFFF);
    expect_reg(irfc_pkg::IDX_DUR3, 32'h03FF_03FF);
    wr(irfc_pkg::IDX_CAP_LOW, 32'h1234_5678);
    expect_reg(irfc_pkg::IDX_CAP_LOW, 32'h0000_0000);
    wr(8'h30, 32'h1234_5678);
    expect_reg(8'h30, 32'h0000_0000);
    for (int f = 0; f < 16; f++) begin
      wr(irfc_pkg::IDX_CTRL, {28'h000_0000, f[3:0]});
      @(posedge clk);
      #1 chk({28'h000_0000, decode_mode}, {28'h000_0000, f[3:0]});
    end
  endtask

  task automatic t_windows;
    logic [9:0] w [6] = '{10'd9, 10'd10, 10'd20, 10'd21, 10'd40, 10'd41};
    logic [5:0] eh = 6'b00_0110;
    logic [5:0] ew = 6'b01_1000;
    wr(irfc_pkg::IDX_DUR2, 32'h0014_000A);
    wr(irfc_pkg::IDX_DUR3, 32'h0028_0015);
    for (int i = 0; i < 6; i++) begin
      rm_u.send_pulse(w[i]);
      #1 chk({31'h0, half_bit_match}, {31'h0, eh[i]});
      chk({31'h0, whole_bit_match}, {31'h0, ew[i]});
    end
  endtask

  task automatic t_capture;
    wr(irfc_pkg::IDX_CTRL, 32'h0000_0000);
    rm_u.send_frame(64'hA5, 8, 2);
    #1 chk({31'h0, frame_valid}, 32'h0000_0001);
    expect_reg(irfc_pkg::IDX_CAP_LOW, 32'h0000_00A5);
    expect_reg(irfc_pkg::IDX_CAP_LOW, 32'h0000_0000);
    chk({31'h0, frame_valid}, 32'h0000_0000);
    wr(irfc_pkg::IDX_CTRL, 32'h0000_0300);
    rm_u.send_frame(64'h01, 8, 0);
    expect_reg(irfc_pkg::IDX_CAP_LOW, 32'h0000_0080);
    expect_reg(irfc_pkg::IDX_CAP_LOW, 32'h0000_0080);
    wr(irfc_pkg::IDX_CTRL, 32'h0000_0000);
    rm_u.send_frame(64'h12_3456_7890, 40, 0);
    expect_reg(irfc_pkg::IDX_STATUS, 32'h8000_0008);
    expect_reg(irfc_pkg::IDX_CAP_HIGH, 32'h0000_0012);
    expect_reg(irfc_pkg::IDX_STATUS, 32'h0000_0008);
    expect_reg(irfc_pkg::IDX_CAP_LOW, 32'h3456_7890);
  endtask

  task automatic t_interval;
    logic [31:0] cv [5] = '{32'h6000, 32'hA000, 32'h2000, 32'hE000, 32'h0000};
    int          gv [5] = '{48, 198, 1998, 48, 48};
    logic [31:0] ev [5] = '{32'd50, 32'd2, 32'd2, 32'd50, 32'd0};
    logic [31:0] a;
    logic [31:0] b;
    for (int i = 0; i < 5; i++) begin
      wr(irfc_pkg::IDX_CTRL, cv[i]);
      rd(irfc_pkg::IDX_LIVE_IVL, a);
      repeat (gv[i]) @(posedge clk);
      rd(irfc_pkg::IDX_LIVE_IVL, b);
      chk(b - a, ev[i]);
    end
    wr(irfc_pkg::IDX_CTRL, 32'h6000);
    rd(irfc_pkg::IDX_LIVE_IVL, a);
    rm_u.send_frame(64'h0, 1, 0);
    expect_reg(irfc_pkg::IDX_LAST_IVL, a + 32'd3);
    rd(irfc_pkg::IDX_LIVE_IVL, b);
    chk_le(b, 32'd4);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    expect_reg(irfc_pkg::IDX_LIVE_IVL, 32'h0000_0000);
  endtask

  task automatic t_repeat;
    logic [31:0] cv [9] = '{32'h0800, 32'h0800, 32'h0800, 32'h7800, 32'h7800,
                            32'h0003_0400, 32'h0003_0400, 32'h0003_0C00, 32'h0028_0400};
    logic [63:0] fv [9] = '{64'h5A, 64'h5A, 64'h3C, 64'h3C, 64'h3C,
                            64'h08, 64'h00, 64'h08, 64'h100_0000_0000};
    logic [31:0] lv [9] = '{32'hF_FFFF, 32'hF_FFFF, 32'hF_FFFF, 32'd5, 32'hF_FFFF,
                            32'hF_FFFF, 32'hF_FFFF, 32'hF_FFFF, 32'hF_FFFF};
    logic [8:0]  ev = 9'h132;
    for (int i = 0; i < 9; i++) begin
      wr(irfc_pkg::IDX_CTRL, cv[i]);
      wr(irfc_pkg::IDX_RPT_LIMIT, lv[i]);
      rm_u.send_frame(fv[i], (i == 8) ? 48 : 8, 0);
      @(posedge clk);
      #1 chk({31'h0, repeat_indicator}, {31'h0, ev[i]});
    end
  endtask

  task automatic t_hold;
    logic [31:0] d;
    wr(irfc_pkg::IDX_CTRL, 32'h0000_0000);
    rd(irfc_pkg::IDX_CAP_LOW, d);
    @(posedge clk);
    hold_first <= 1'b1;
    rm_u.send_frame(64'h11, 8, 0);
    rm_u.send_frame(64'h22, 8, 0);
    expect_reg(irfc_pkg::IDX_CAP_LOW, 32'h0000_0011);
    rm_u.send_frame(64'h33, 8, 0);
    expect_reg(irfc_pkg::IDX_CAP_LOW, 32'h0000_0033);
    @(posedge clk);
    hold_first <= 1'b0;
  endtask

  initial begin
    #5_000_000;
    n_mismatch++;
    final_report();
  end

  initial begin
    rst        = 1'b1;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0000_0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    hold_first = 1'b0;
    n_mismatch = 0;
    cmp_count  = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_windows();
    t_capture();
    t_interval();
    t_repeat();
    t_hold();
    final_report();
  end
endmodule
